//--- iwdt_top.sv
// Inactivity watchdog timer with Avalon-MM register slave
//
// Contract
// R1: Timeout 1 to 255 units, unit in status
// R2: Minutes by default, seconds when selected
// R3: Eight-bit down counter, one step per unit
// R4: Four activity inputs: keyboard, mouse, two serials
// R5: Input restarts only when its mask bit set
// R6: Reset clears timeout, idles, output high, masked
// R7: Timeout write activates, loads, starts counting
// R8: Enabled trigger before zero reloads the counter
// R9: Counter stops at zero without triggers
// R10: At zero output low, status bit zero
// R11: Any timeout write releases output, status one
// R12: Writing zero deactivates the timer
// R13: Non-zero write starts new countdown
// R14: Assigned interrupt active while status low
// R15: Expiry on pin, interrupt line, status bit
// R16: Status mirrors pin and holds time unit
// R17: Non-zero write while running reloads at once
// R18: Mask bits keyboard, mouse, serial1, serial2
// R19: Prescaler makes one-cycle second/minute tick
// R20: Triggers level-active, synchronised before use
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "iwdt_defines.svh"

module iwdt_top #(
    parameter int SEC_CYCLES = `IWDT_SEC_CYCLES,
    parameter int MIN_CYCLES = `IWDT_MIN_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic KEYBOARD_IRQ_SOURCE,
    input wire logic MOUSE_IRQ_SOURCE,
    input wire logic FIRST_SERIAL_PORT,
    input wire logic SECOND_SERIAL_PORT,
    input wire logic IRQ_ROUTE_EN,
    output logic EXPIRY_OUTPUT_N,
    output logic SYSTEM_MGMT_INTERRUPT_N,
    output logic WDT_IRQ
);

    // ------------------------------------------------------------------------
    // Trigger synchronisers
    // ------------------------------------------------------------------------
    logic [`IWDT_MASK_BITS-1:0] trig_raw;
    logic [`IWDT_MASK_BITS-1:0] sync1;
    logic [`IWDT_MASK_BITS-1:0] sync2;
    logic route_s1;
    logic route_s2;
    assign trig_raw = {SECOND_SERIAL_PORT, FIRST_SERIAL_PORT, MOUSE_IRQ_SOURCE,
                       KEYBOARD_IRQ_SOURCE}; // [R4] [R18]

    genvar gi;
    generate
        for (gi = 0; gi < `IWDT_MASK_BITS; gi = gi + 1) begin : g_sync
            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= trig_raw[gi]; // [R20]
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            route_s1 <= 1'b0;
            route_s2 <= 1'b0;
        end else begin
            route_s1 <= IRQ_ROUTE_EN;
            route_s2 <= route_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    logic [7:0] timeout_period_reg;
    logic [`IWDT_MASK_BITS-1:0] trigger_mask_reg;
    logic time_unit;
    logic expiry;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] next_timeout;
    logic [`IWDT_MASK_BITS-1:0] next_mask;
    logic next_unit;
    logic next_ack;
    logic [31:0] next_rdata;
    logic req;
    logic wr_fire;
    logic to_write;

    // One wait state: request is taken on the edge where waitrequest is low
    assign req = (AVS_READ | AVS_WRITE) & ~ack;
    assign wr_fire = AVS_WRITE & ack;
    assign to_write = wr_fire & (AVS_ADDRESS == `IWDT_IDX_TIMEOUT) & AVS_BYTEENABLE[0];

    always_comb begin
        next_timeout = timeout_period_reg;
        next_mask = trigger_mask_reg;
        next_unit = time_unit;
        next_ack = req;
        next_rdata = 32'h00000000;
        if (wr_fire && AVS_BYTEENABLE[0]) begin
            case (AVS_ADDRESS)
                `IWDT_IDX_TIMEOUT: next_timeout = AVS_WRITEDATA[7:0]; // [R1]
                `IWDT_IDX_MASK: next_mask = AVS_WRITEDATA[`IWDT_MASK_BITS-1:0]; // [R18]
                // Unit bit is writable here; expiry bit is read only
                `IWDT_IDX_STATUS: next_unit = AVS_WRITEDATA[`IWDT_STAT_UNIT_BIT]; // [R2]
                default: next_timeout = timeout_period_reg;
            endcase
        end
        if (req && AVS_READ) begin
            case (AVS_ADDRESS)
                `IWDT_IDX_TIMEOUT: next_rdata = {24'h000000, timeout_period_reg};
                `IWDT_IDX_MASK: next_rdata = {28'h0000000, trigger_mask_reg};
                `IWDT_IDX_STATUS: begin
                    next_rdata[`IWDT_STAT_UNIT_BIT] = time_unit; // [R16]
                    next_rdata[`IWDT_STAT_EXPIRY_BIT] = ~expiry; // [R16] [R15]
                end
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            timeout_period_reg <= `IWDT_TIMEOUT_RST; // [R6]
            trigger_mask_reg <= `IWDT_MASK_BITS'(`IWDT_MASK_RST); // [R6]
            time_unit <= 1'b0; // [R2]
            ack <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            rdata <= 32'h00000000;
        end else begin
            timeout_period_reg <= next_timeout;
            trigger_mask_reg <= next_mask;
            time_unit <= next_unit;
            ack <= next_ack;
            AVS_WAITREQUEST <= ~next_ack;
            rdata <= next_rdata;
        end
    end

    assign AVS_READDATA = rdata;

    // ------------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------------
    logic [31:0] pre_cnt;
    logic [31:0] next_pre;
    logic tick;
    logic next_tick;
    logic [31:0] pre_limit;
    logic restart;
    assign pre_limit = time_unit ? 32'(SEC_CYCLES - 1) : 32'(MIN_CYCLES - 1); // [R2]

    // ------------------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------------------
    iwdt_pkg::iwdt_state_t state;
    iwdt_pkg::iwdt_state_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_expiry;
    logic trig_hit;
    assign trig_hit = |(sync2 & trigger_mask_reg); // [R5]
    // Unit boundaries restart with each load so the first step is a full unit
    assign restart = to_write | (state == iwdt_pkg::IWDT_RUN && trig_hit);

    always_comb begin
        next_pre = pre_cnt + 32'h00000001;
        next_tick = 1'b0;
        if (restart || state != iwdt_pkg::IWDT_RUN) begin
            next_pre = 32'h00000000;
        end else if (pre_cnt >= pre_limit) begin
            next_pre = 32'h00000000;
            next_tick = 1'b1; // [R19]
        end
    end

    always_comb begin
        next_state = state;
        next_count = count;
        next_expiry = expiry;
        case (state)
            iwdt_pkg::IWDT_IDLE: next_expiry = 1'b0;
            iwdt_pkg::IWDT_RUN: begin
                if (trig_hit) begin
                    next_count = timeout_period_reg; // [R8]
                end else if (tick) begin
                    next_count = count - 8'h01; // [R3]
                    if (count == 8'h01) begin
                        next_state = iwdt_pkg::IWDT_EXPIRED; // [R9]
                        next_expiry = 1'b1; // [R10]
                    end
                end
            end
            iwdt_pkg::IWDT_EXPIRED: next_count = 8'h00; // [R9]
            default: next_state = iwdt_pkg::IWDT_IDLE;
        endcase
        if (to_write) begin
            next_expiry = 1'b0; // [R11]
            next_count = AVS_WRITEDATA[7:0]; // [R7] [R17]
            if (AVS_WRITEDATA[7:0] == 8'h00) begin
                next_state = iwdt_pkg::IWDT_IDLE; // [R12]
            end else begin
                next_state = iwdt_pkg::IWDT_RUN; // [R13]
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state <= iwdt_pkg::IWDT_IDLE; // [R6]
            count <= 8'h00;
            expiry <= 1'b0;
            pre_cnt <= 32'h00000000;
            tick <= 1'b0;
            EXPIRY_OUTPUT_N <= 1'b1; // [R6]
            SYSTEM_MGMT_INTERRUPT_N <= 1'b1;
            WDT_IRQ <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            expiry <= next_expiry;
            pre_cnt <= next_pre;
            tick <= next_tick;
            EXPIRY_OUTPUT_N <= ~next_expiry; // [R10] [R15]
            SYSTEM_MGMT_INTERRUPT_N <= ~next_expiry; // [R15]
            WDT_IRQ <= next_expiry & route_s2; // [R14]
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_WRITE_RELEASES: assert property ( // [R11]
        @(posedge REF_CLK) disable iff (RST)
        to_write |=> EXPIRY_OUTPUT_N)
        else $error("timeout write did not release output");
    AST_ZERO_IDLES: assert property ( // [R12]
        @(posedge REF_CLK) disable iff (RST)
        to_write && AVS_WRITEDATA[7:0] == 8'h00 |=> state == iwdt_pkg::IWDT_IDLE)
        else $error("zero write did not idle");
    AST_LOAD: assert property ( // [R7]
        @(posedge REF_CLK) disable iff (RST)
        to_write |=> count == $past(AVS_WRITEDATA[7:0]))
        else $error("counter not loaded");
    AST_RELOAD: assert property ( // [R8]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_RUN && trig_hit && !to_write |=> count == timeout_period_reg)
        else $error("trigger did not reload");
    AST_EXPIRE: assert property ( // [R10]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_RUN && tick && !trig_hit && !to_write && count == 8'h01
        |=> !EXPIRY_OUTPUT_N && count == 8'h00) else $error("no expiry at zero");
    AST_HOLD_ZERO: assert property ( // [R9]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_EXPIRED && !to_write |=> $stable(count) && !EXPIRY_OUTPUT_N)
        else $error("counter moved after expiry");
    AST_STEP: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_RUN && tick && !trig_hit && !to_write
        |=> count == $past(count) - 8'h01) else $error("bad decrement");
    AST_MASKED: assert property ( // [R5]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_RUN && !tick && !trig_hit && !to_write |=> $stable(count))
        else $error("count moved without cause");
    AST_IDLE_OUT: assert property ( // [R12]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_IDLE |-> EXPIRY_OUTPUT_N && !WDT_IRQ)
        else $error("idle output active");
    AST_TICK_PULSE: assert property ( // [R19]
        @(posedge REF_CLK) disable iff (RST)
        tick |=> !tick)
        else $error("tick wider than one cycle");
    AST_IDLE_STILL: assert property ( // [R12]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_IDLE && !to_write |=> count == 8'h00 && !tick)
        else $error("countdown runs while idle");
    AST_IRQ_LEVEL: assert property ( // [R14]
        @(posedge REF_CLK) disable iff (RST)
        state == iwdt_pkg::IWDT_EXPIRED && route_s2 && !to_write |=> WDT_IRQ)
        else $error("routed interrupt not held while expired");
    // Read data is latched one edge before it is presented, so it shows the earlier pin level
    AST_STATUS_PIN: assert property ( // [R16]
        @(posedge REF_CLK) disable iff (RST)
        req && AVS_READ && AVS_ADDRESS == `IWDT_IDX_STATUS
        |=> AVS_READDATA[`IWDT_STAT_EXPIRY_BIT] == $past(EXPIRY_OUTPUT_N))
        else $error("status bit does not follow the expiry pin");
    AST_RESET_STATE: assert property ( // [R6]
        @(posedge REF_CLK)
        RST |=> state == iwdt_pkg::IWDT_IDLE && EXPIRY_OUTPUT_N && AVS_WAITREQUEST
            && timeout_period_reg == 8'h00 && trigger_mask_reg == 4'h0)
        else $error("reset did not clear the watchdog");

endmodule

//--- iwdt_defines.svh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef IWDT_DEFINES_SVH
`define IWDT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IWDT_IDX_TIMEOUT 2'h0
`define IWDT_IDX_MASK 2'h1
`define IWDT_IDX_STATUS 2'h2

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define IWDT_MASK_BITS 4
`define IWDT_STAT_EXPIRY_BIT 0
`define IWDT_STAT_UNIT_BIT 7
`define IWDT_TIMEOUT_RST 8'h00
`define IWDT_MASK_RST 8'h00
`define IWDT_STATUS_RST 8'h01

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IWDT_CLK_HZ 10000000
`define IWDT_SECOND_S 1
`define IWDT_MINUTE_S 60
`define IWDT_SEC_CYCLES (`IWDT_CLK_HZ * `IWDT_SECOND_S)
`define IWDT_MIN_CYCLES (`IWDT_CLK_HZ * `IWDT_MINUTE_S)

`endif

//--- iwdt_pkg.sv
// Types shared by the watchdog design
package iwdt_pkg;
    typedef enum logic [1:0] {
        IWDT_IDLE = 2'b00,
        IWDT_RUN = 2'b01,
        IWDT_EXPIRED = 2'b10
    } iwdt_state_t;
endpackage

//--- iwdt_src_model.sv
// Model of the four peripheral interrupt lines that feed the watchdog
`timescale 1ns/1ps
module iwdt_src_model (
    input wire logic clk,
    input wire logic [3:0] req,
    output logic [3:0] irq
);
    // Lines move only after an edge, as a peripheral's request flop would
    initial irq = 4'h0;
    always @(posedge clk) begin
        irq <= req;
    end
endmodule

//--- tb_top.sv
// Self-checking bench of the inactivity watchdog
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    // ------------------------------------------------------------------
    // Short prescaler counts keep the run brief
    // ------------------------------------------------------------------
    localparam int SEC = 4;
    localparam int MIN = 8;
    localparam logic [17:0] ROWS [6] = '{{2'h1, 8'hff, 8'h0f}, {2'h1, 8'h05, 8'h05},
        {2'h2, 8'h80, 8'h81}, {2'h2, 8'h00, 8'h01}, {2'h3, 8'h5a, 8'h00}, {2'h0, 8'h00, 8'h00}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic route = 1'b0;
    logic [3:0] req = 4'h0;
    logic [3:0] irq;
    logic [31:0] rdata;
    logic wait_req;
    logic exp_n;
    logic smi_n;
    logic wdt_irq;
    logic [7:0] q;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    iwdt_src_model iwdt_src_model_i (.clk(clk), .req(req), .irq(irq));
    iwdt_top #(.SEC_CYCLES(SEC), .MIN_CYCLES(MIN)) iwdt_top_i (
        .REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .KEYBOARD_IRQ_SOURCE(irq[0]), .MOUSE_IRQ_SOURCE(irq[1]),
        .FIRST_SERIAL_PORT(irq[2]), .SECOND_SERIAL_PORT(irq[3]), .IRQ_ROUTE_EN(route),
        .EXPIRY_OUTPUT_N(exp_n), .SYSTEM_MGMT_INTERRUPT_N(smi_n), .WDT_IRQ(wdt_irq));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low; one idle edge follows
    task bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        // Only the bench timeout ends a wait that never sees waitrequest low
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task rd_exp(input logic [1:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask

    // Must stay high until shortly before t cycles, then fall within a few
    task expire(input int t);
        int n;
        n = 0;
        repeat (t - 2) @(posedge clk);
        `CHK(exp_n, 1'b1)
        while (exp_n !== 1'b0 && n < 12) begin
            @(posedge clk);
            n++;
        end
        `CHK(exp_n, 1'b0)
    endtask

    task reset_chk();
        `CHK({exp_n, smi_n, wdt_irq, wait_req}, 4'b1101)
        rd_exp(2'h0, 8'h00);
        rd_exp(2'h1, 8'h00);
        rd_exp(2'h2, 8'h01);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reset_chk();
        foreach (ROWS[r]) begin
            bus(1'b1, ROWS[r][17:16], ROWS[r][15:8]);
            rd_exp(ROWS[r][17:16], ROWS[r][7:0]);
        end
        bus(1'b1, 2'h0, 8'h02);
        expire(2 * MIN);
        rd_exp(2'h2, 8'h00);
        `CHK({smi_n, wdt_irq}, 2'b00)
        route <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(wdt_irq, 1'b1)
        bus(1'b1, 2'h0, 8'h00);
        repeat (2) @(posedge clk);
        `CHK({exp_n, smi_n, wdt_irq}, 3'b110)
        repeat (40) @(posedge clk);
        `CHK(exp_n, 1'b1)
        bus(1'b1, 2'h2, 8'h80);
        bus(1'b1, 2'h0, 8'h03);
        expire(3 * SEC);
        bus(1'b1, 2'h0, 8'h03);
        `CHK(exp_n, 1'b1)
        rd_exp(2'h2, 8'h81);
        repeat (4) @(posedge clk);
        bus(1'b1, 2'h0, 8'h03);
        expire(3 * SEC);
        // Each source alone, first masked, then enabled and held
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 4; i++) begin
                bus(1'b1, 2'h1, e[0] ? (8'h01 << i) : (8'h0f ^ (8'h01 << i)));
                req <= 4'h1 << i;
                bus(1'b1, 2'h0, 8'h02);
                repeat (30) @(posedge clk);
                `CHK(exp_n, e[0])
                req <= 4'h0;
                @(posedge clk);
                if (e == 1) begin
                    expire(2 * SEC);
                end
            end
        end
        bus(1'b1, 2'h1, 8'h0f);
        bus(1'b1, 2'h0, 8'h09);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reset_chk();
        results();
    end
endmodule
